// ### bench/smws_chk_assertions.sv
// Port checker of the mode and wake sequencer.
`timescale 1ns/100ps
module smws_chk #(
  parameter int NRQ_TIMEOUT_CYC = 200,
  parameter int RST_HOLD_CYC = 50,
  parameter int STOP_WATCHDOG_FAULT_OUTPUT_CYC = 300
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic spi_csn_in,
  input wire logic stop_watchdog_fault_output_en_in,
  input wire logic can_wake_in,
  input wire logic input_wake_in,
  input wire logic rst_n_out,
  input wire logic int_n_out,
  input wire logic spi_ready_out,
  input wire logic [1:0] wake_src_out,
  input wire logic [2:0] mode_out
);
  localparam logic [2:0] RST = smws_pkg::SMWS_RESET;
  localparam logic [2:0] NRQ = smws_pkg::SMWS_NREQ;
  localparam logic [2:0] STP = smws_pkg::SMWS_STOP;
  localparam int FS = smws_pkg::FIRST_SPI_CYC;
  logic [31:0] ncnt_r, rcnt_r, scnt_r, lcnt_r, fcnt_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Dwell counters; long waits are counted here because repetition would unroll too far.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ncnt_r <= 32'h0;
      rcnt_r <= 32'h0;
      scnt_r <= 32'h0;
      lcnt_r <= 32'h0;
      fcnt_r <= 32'h0;
    end else begin
      ncnt_r <= (mode_out == NRQ) ? ncnt_r + 32'h1 : 32'h0;
      rcnt_r <= (mode_out == RST) ? rcnt_r + 32'h1 : 32'h0;
      scnt_r <= (mode_out == STP && stop_watchdog_fault_output_en_in) ? scnt_r + 32'h1 : 32'h0;
      lcnt_r <= !int_n_out ? lcnt_r + 32'h1 : 32'h0;
      fcnt_r <= (int_n_out && !spi_ready_out) ? fcnt_r + 32'h1 : 32'h0;
    end
  end
  chk_nreq_timeout: assert property (ncnt_r <= NRQ_TIMEOUT_CYC + 3) else $error("nreq overstay");
  chk_reset_exit: assert property ($past(mode_out) == RST && mode_out != RST |->
    mode_out == NRQ && $past(rcnt_r) >= RST_HOLD_CYC - 2) else $error("bad reset exit");
  chk_stop_exit: assert property ($past(mode_out) == STP && mode_out != STP |->
    mode_out == NRQ) else $error("stop exit not nreq");
  chk_stop_entry: assert property (mode_out == STP && $past(mode_out) != STP |->
    $past(mode_out) == smws_pkg::SMWS_RUN && $past(spi_csn_in)) else $error("bad stop entry");
  chk_int_in_nreq: assert property ($fell(int_n_out) |-> mode_out == NRQ && !spi_ready_out)
    else $error("pulse outside nreq");
  chk_int_width: assert property ($rose(int_n_out) |-> $past(lcnt_r) inside {[1240:1260]})
    else $error("pulse width");
  chk_spi_gap: assert property ($rose(spi_ready_out) |-> $past(fcnt_r) inside {[FS-2:FS+2]})
    else $error("first access delay");
  chk_spi_delay: assert property ($rose(int_n_out) |-> !spi_ready_out [*8]) else $error("spi too early");
  chk_can_flag: assert property ($rose(wake_src_out[0]) |-> $past(can_wake_in, 3)) else $error("can flag");
  chk_input_flag: assert property ($rose(wake_src_out[1]) |-> $past(input_wake_in, 3)) else $error("input flag");
  chk_stop_watchdog_fault_output: assert property (scnt_r <= STOP_WATCHDOG_FAULT_OUTPUT_CYC + 3) else $error("stop watchdog late");
  cover property ($fell(int_n_out));
  cover property ($rose(mode_out == STP));
  cover property ($rose(mode_out == smws_pkg::SMWS_SLEEP));
endmodule
bind smws_top smws_chk #(.NRQ_TIMEOUT_CYC(NRQ_TIMEOUT_CYC), .RST_HOLD_CYC(RST_HOLD_CYC),
  .STOP_WATCHDOG_FAULT_OUTPUT_CYC(STOP_WATCHDOG_FAULT_OUTPUT_CYC)) u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .spi_csn_in(spi_csn_in),
  .stop_watchdog_fault_output_en_in(stop_watchdog_fault_output_en_in), .can_wake_in(can_wake_in), .input_wake_in(input_wake_in),
  .rst_n_out(rst_n_out), .int_n_out(int_n_out), .spi_ready_out(spi_ready_out),
  .wake_src_out(wake_src_out), .mode_out(mode_out));

// ### bench/smws_host.sv
// Host controller model driving chip select and decoded command strobes.
`timescale 1ns/100ps
module smws_host (
  input wire logic clk_in,
  input wire logic spi_ready_in,
  output logic spi_csn_out,
  output logic watchdog_fault_output_config_out,
  output logic stop_cmd_out,
  output logic run_cmd_out
);
  // Chip select idles high between frames and strobes idle low.
  initial begin
    spi_csn_out = 1'h1;
    watchdog_fault_output_config_out = 1'h0;
    stop_cmd_out = 1'h0;
    run_cmd_out = 1'h0;
  end
  // Waits out the first access delay, then writes the watchdog timing.
  task configure();
    int i;
    for (i = 0; i < 4000 && spi_ready_in !== 1'h1; i++) @(posedge clk_in);
    @(posedge clk_in) watchdog_fault_output_config_out <= 1'h1;
    @(posedge clk_in) watchdog_fault_output_config_out <= 1'h0;
  endtask
  // A Stop frame; the mode changes only when chip select rises, unless a run command cancels it.
  task go_stop(input logic cancel);
    @(posedge clk_in) spi_csn_out <= 1'h0;
    stop_cmd_out <= 1'h1;
    @(posedge clk_in) stop_cmd_out <= 1'h0;
    run_cmd_out <= cancel;
    @(posedge clk_in) run_cmd_out <= 1'h0;
    repeat (3) @(posedge clk_in);
    spi_csn_out <= 1'h1;
  endtask
  // Short chip select frame used as a wake from Stop.
  task cs_wake();
    @(posedge clk_in) spi_csn_out <= 1'h0;
    repeat (4) @(posedge clk_in);
    spi_csn_out <= 1'h1;
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench of the mode and wake sequencer.
`timescale 1ns/100ps
module tb_top;
  localparam logic [2:0] RST = smws_pkg::SMWS_RESET;
  localparam logic [2:0] NRQ = smws_pkg::SMWS_NREQ;
  localparam logic [2:0] RUN = smws_pkg::SMWS_RUN;
  localparam logic [2:0] STP = smws_pkg::SMWS_STOP;
  logic clk_in, rstn_in, csn, cfg, stp, runc, slp, swk, wd_en, can_w, in_w, fwu, oc, clr;
  logic rst_n, int_n, rdy, rst_seen;
  logic [1:0] src;
  logic [2:0] mode;
  int errors, comparisons;
  // Clock of 8 ns and time-zero input values.
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end
  initial {rstn_in, slp, swk, wd_en, can_w, in_w, fwu, oc, clr, rst_seen} = 10'h0;
  // Remembers a reset pulse from the device.
  always @(posedge clk_in) if (rstn_in && rst_n === 1'h0) rst_seen <= 1'h1;
  smws_host host (.clk_in(clk_in), .spi_ready_in(rdy), .spi_csn_out(csn), .watchdog_fault_output_config_out(cfg),
    .stop_cmd_out(stp), .run_cmd_out(runc));
  smws_top #(.NRQ_TIMEOUT_CYC(5000), .RST_HOLD_CYC(50), .STOP_WATCHDOG_FAULT_OUTPUT_CYC(300)) dut (.clk_in(clk_in),
    .rstn_in(rstn_in), .spi_csn_in(csn), .watchdog_fault_output_config_in(cfg), .stop_cmd_in(stp), .sleep_cmd_in(slp),
    .run_cmd_in(runc), .sleep_wake_in(swk), .stop_watchdog_fault_output_en_in(wd_en), .can_wake_in(can_w),
    .input_wake_in(in_w), .forced_wake_in(fwu), .over_current_in(oc), .wake_src_clear_in(clr),
    .rst_n_out(rst_n), .int_n_out(int_n), .spi_ready_out(rdy), .wake_src_out(src), .mode_out(mode));
  task cmp(input logic [2:0] g, input logic [2:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bounded wait for a mode, sampled after the edge has settled.
  task wt(input logic [2:0] m, input int n);
    int i;
    for (i = 0; i < n && mode !== m; i++) @(posedge clk_in) #1;
    cmp(mode, m);
  endtask
  task t_power();
    wt(NRQ, 60);
    cmp(rst_n, 3'h1);
    wt(RST, 5010);
    cmp(rst_n, 3'h0);
    wt(NRQ, 60);
    $display("power loop done");
  endtask
  task t_wake(input int k);
    int i;
    host.configure();
    wt(RUN, 20);
    @(posedge clk_in) wd_en <= (k != 4);
    host.go_stop(1'h0);
    wt(STP, 10);
    @(posedge clk_in);
    case (k)
      0: can_w <= 1'h1;
      1: in_w <= 1'h1;
      2: fwu <= 1'h1;
      4: begin
        oc <= 1'h1;
        repeat (100) @(posedge clk_in);
        cmp(mode, STP);
      end
      default: host.cs_wake();
    endcase
    wt(NRQ, 5100);
    for (i = 0; i < 5 && int_n !== 1'h0; i++) @(posedge clk_in) #1;
    cmp(int_n, 3'h0);
    cmp(rdy, 3'h0);
    @(posedge clk_in) {can_w, in_w, fwu, oc} <= 4'h0;
    for (i = 0; i < 4000 && rdy !== 1'h1; i++) @(posedge clk_in) #1;
    cmp(int_n, 3'h1);
    cmp(src, (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : 3'h0);
    @(posedge clk_in) clr <= 1'h1;
    @(posedge clk_in) clr <= 1'h0;
    $display("wake kind %0d done", k);
  endtask
  task t_watchdog_fault_output();
    host.configure();
    wt(RUN, 20);
    @(posedge clk_in) wd_en <= 1'h1;
    rst_seen <= 1'h0;
    host.go_stop(1'h0);
    wt(STP, 10);
    wt(NRQ, 320);
    // The reset pulse is caught one edge later, and a wrong pulse would show within two.
    repeat (3) @(posedge clk_in) #1;
    cmp(int_n, 3'h1);
    cmp(rst_seen, 3'h1);
    wd_en <= 1'h0;
    $display("stop watchdog done");
  endtask
  task t_sleep();
    host.configure();
    wt(RUN, 20);
    // A run command inside the Stop frame cancels the armed Stop.
    host.go_stop(1'h1);
    repeat (8) @(posedge clk_in) #1;
    cmp(mode, RUN);
    @(posedge clk_in) slp <= 1'h1;
    @(posedge clk_in) slp <= 1'h0;
    wt(smws_pkg::SMWS_SLEEP, 5);
    @(posedge clk_in) swk <= 1'h1;
    @(posedge clk_in) swk <= 1'h0;
    wt(NRQ, 70);
    wt(smws_pkg::SMWS_SLEEP, 5010);
    $display("sleep return done");
  endtask
  task finish_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'h1;
    t_power();
    for (int k = 0; k < 5; k++) t_wake(k);
    t_watchdog_fault_output();
    t_sleep();
    finish_test();
  end
  // Watchdog at 75000 cycles, about twice the span the tests need.
  initial begin
    #600000;
    errors++;
    finish_test();
  end
endmodule

// ### logic/smws_sync.sv
// Two-flip-flop synchroniser for an asynchronous level.
`timescale 1ns/100ps
module smws_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

// ### logic/smws_timer.sv
// Down-counting one-shot timer used for every sequencer delay.
`timescale 1ns/100ps
module smws_timer #(
  parameter int W = 32
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  input wire logic stop_in,
  output logic busy_out,
  output logic done_out
);

  logic [W-1:0] cnt_r;
  logic done_r;

  // A start restarts the count even while busy; done pulses one cycle at zero.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (start_in) begin
      cnt_r <= load_in;
      done_r <= 1'b0;
    end else if (stop_in) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
      cnt_r <= (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    end
  end

  assign busy_out = (cnt_r != '0);
  assign done_out = done_r;

endmodule

// ### logic/smws_top.sv
// Operating-mode sequencer: Normal Request timeout, Stop entry and Stop wake-up.
// Function
// R01: Unconfigured Normal Request after power or Stop resets.
// R02: Keep cycling Normal Request and Reset forever.
// R03: Unconfigured Normal Request after Sleep returns Sleep.
// R04: Chip-side Stop wake enters Normal Request, interrupts.
// R05: Chip select rising edge wakes from Stop.
// R06: Over-current wake: interrupt, no flag set.
// R07: Enter Normal Request first, then 10 us pulse.
// R08: Record CAN or input wake source flag.
// R09: Over-current or forced wake sets no source.
// R10: SPI accepted only after first access delay.
// R11: Host wakes by chip select before watchdog ends.
// R12: Stop watchdog expiry asserts reset, enters Normal Request.
// R13: Stop entered on chip select rising edge.
// R14: Over-current wake deglitched 40 us after entry.
// R15: Normal Request entry starts 350 ms timer.
// R16: Reset holds reset low, then Normal Request.
// R17: Stop wake skips Reset mode.
// R18: Host configures watchdog timing during Normal Request.
// R19: Interrupt output active low, idles high.
`timescale 1ns/100ps
module smws_top #(
  parameter int NRQ_TIMEOUT_CYC = smws_pkg::NRQ_TIMEOUT_CYC,
  parameter int RST_HOLD_CYC = smws_pkg::RST_HOLD_CYC,
  parameter int STOP_WATCHDOG_FAULT_OUTPUT_CYC = smws_pkg::STOP_WATCHDOG_FAULT_OUTPUT_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic spi_csn_in,
  input wire logic watchdog_fault_output_config_in,
  input wire logic stop_cmd_in,
  input wire logic sleep_cmd_in,
  input wire logic run_cmd_in,
  input wire logic sleep_wake_in,
  input wire logic stop_watchdog_fault_output_en_in,
  input wire logic can_wake_in,
  input wire logic input_wake_in,
  input wire logic forced_wake_in,
  input wire logic over_current_in,
  input wire logic wake_src_clear_in,
  output logic rst_n_out,
  output logic int_n_out,
  output logic spi_ready_out,
  output logic [1:0] wake_src_out,
  output logic [2:0] mode_out
);

  localparam int W = smws_pkg::CNT_W;

  smws_pkg::smws_state_t state_r;
  smws_pkg::smws_state_t state_nxt;
  logic [1:0] origin_r;
  logic stop_pending_r;
  logic csn_prev_r;
  logic int_n_r;
  logic spi_ready_r;
  logic [1:0] wake_src_r;
  logic rst_n_r;
  logic csn_s;
  logic cs_act_s;
  smws_pkg::smws_wake_t wake_raw;
  smws_pkg::smws_wake_t wake_s;

  // The chip-side wake pins and chip select pass a two-stage synchroniser; sleep_wake_in is used unsynchronised.
  assign wake_raw = '{can_wake: can_wake_in, input_wake: input_wake_in,
                      forced_wake: forced_wake_in, over_current: over_current_in};

  // The synchroniser clears to zero, so it carries the active level of chip select.
  // An idle-high pin then reads as idle straight out of reset and no false rising edge follows.
  smws_sync #(.W(1)) u_sync_cs (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(~spi_csn_in),
    .q_out(cs_act_s)
  );
  assign csn_s = ~cs_act_s;

  smws_sync #(.W(4)) u_sync_wake (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .d_in(wake_raw),
    .q_out(wake_s)
  );

  // Timer control wires.
  logic nrq_start;
  logic nrq_stop;
  logic nrq_done;
  logic rst_start;
  logic rst_done;
  logic rst_busy;
  logic wd_start;
  logic wd_done;
  logic oc_start;
  logic oc_busy;
  logic ip_start;
  logic ip_done;
  logic ip_busy;
  logic fs_start;
  logic fs_busy;

  // Decode of events.
  logic cs_rise;
  logic in_stop;
  logic oc_wake;
  logic chip_wake;
  logic host_wake;
  logic wd_expire;
  logic stop_wake;
  logic cfg_ok;
  assign cs_rise = csn_s & ~csn_prev_r;
  assign in_stop = (state_r == smws_pkg::SMWS_STOP);
  assign oc_wake = in_stop & wake_s.over_current & ~oc_busy; // R14
  assign chip_wake = in_stop & (wake_s.can_wake | wake_s.input_wake | wake_s.forced_wake); // R04
  assign host_wake = in_stop & cs_rise; // R05 R11
  assign wd_expire = in_stop & stop_watchdog_fault_output_en_in & wd_done; // R12
  assign stop_wake = chip_wake | host_wake | oc_wake | wd_expire;
  // Commands are refused until the first-access delay after a wake has run out.
  assign cfg_ok = watchdog_fault_output_config_in & spi_ready_r; // R10

  // Timer starts follow the transitions taken this cycle.
  assign nrq_start = (state_nxt == smws_pkg::SMWS_NREQ) && (state_r != smws_pkg::SMWS_NREQ); // R15
  assign nrq_stop = (state_r == smws_pkg::SMWS_NREQ) && cfg_ok; // R18
  // An idle hold timer in Reset starts it, which also covers the first cycle after power-up.
  assign rst_start = (state_nxt == smws_pkg::SMWS_RESET) && !rst_busy && !rst_done; // R16
  assign wd_start = (state_nxt == smws_pkg::SMWS_STOP) && (state_r != smws_pkg::SMWS_STOP);
  assign oc_start = wd_start; // R14
  assign ip_start = in_stop && stop_wake && !wd_expire; // R07
  assign fs_start = ip_done; // R10

  // Normal Request timeout; a watchdog configuration stops it early.
  smws_timer #(
    .W(W)
  ) u_nrq (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(nrq_start),
    .load_in(W'(NRQ_TIMEOUT_CYC)),
    .stop_in(nrq_stop),
    .busy_out(),
    .done_out(nrq_done)
  );

  // Reset hold; the mode leaves Reset on its done pulse.
  smws_timer #(
    .W(W)
  ) u_rst (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(rst_start),
    .load_in(W'(RST_HOLD_CYC)),
    .stop_in(1'b0),
    .busy_out(rst_busy),
    .done_out(rst_done)
  );

  // Stop watchdog; held clear outside Stop so a stale done pulse cannot leak into another mode.
  smws_timer #(
    .W(W)
  ) u_wd (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(wd_start),
    .load_in(W'(STOP_WATCHDOG_FAULT_OUTPUT_CYC)),
    .stop_in(~in_stop),
    .busy_out(),
    .done_out(wd_done)
  );

  // Over-current deglitch, restarted on every Stop entry so the host can settle first.
  smws_timer #(
    .W(W)
  ) u_oc (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(oc_start),
    .load_in(W'(smws_pkg::OC_DEGLITCH_CYC)),
    .stop_in(1'b0),
    .busy_out(oc_busy),
    .done_out()
  );

  // Wake interrupt pulse width.
  smws_timer #(
    .W(W)
  ) u_ip (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(ip_start),
    .load_in(W'(smws_pkg::INT_PULSE_CYC)),
    .stop_in(1'b0),
    .busy_out(ip_busy),
    .done_out(ip_done)
  );

  // First-access delay, chained to the end of the pulse so the two never overlap.
  smws_timer #(
    .W(W)
  ) u_fs (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(fs_start),
    .load_in(W'(smws_pkg::FIRST_SPI_CYC)),
    .stop_in(1'b0),
    .busy_out(fs_busy),
    .done_out()
  );

  // Next-mode selection; a Stop command takes effect only at the frame's chip select rise.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      smws_pkg::SMWS_RESET: begin
        if (rst_done) begin
          state_nxt = smws_pkg::SMWS_NREQ; // R16
        end
      end
      smws_pkg::SMWS_NREQ: begin
        if (cfg_ok) begin
          state_nxt = smws_pkg::SMWS_RUN; // R18
        end else if (nrq_done && origin_r == smws_pkg::ORG_SLEEP) begin
          state_nxt = smws_pkg::SMWS_SLEEP; // R03
        end else if (nrq_done) begin
          state_nxt = smws_pkg::SMWS_RESET; // R01 R02
        end
      end
      smws_pkg::SMWS_RUN: begin
        if (stop_pending_r && cs_rise) begin
          state_nxt = smws_pkg::SMWS_STOP; // R13
        end else if (sleep_cmd_in) begin
          state_nxt = smws_pkg::SMWS_SLEEP;
        end
      end
      smws_pkg::SMWS_STOP: begin
        if (stop_wake) begin
          state_nxt = smws_pkg::SMWS_NREQ; // R17
        end
      end
      smws_pkg::SMWS_SLEEP: begin
        if (sleep_wake_in) begin
          state_nxt = smws_pkg::SMWS_RESET;
        end
      end
      default: begin
        state_nxt = smws_pkg::SMWS_RESET;
      end
    endcase
  end

  // Mode register, origin of each Normal Request visit and the armed Stop command.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= smws_pkg::SMWS_RESET;
      origin_r <= smws_pkg::ORG_POWER;
      stop_pending_r <= 1'b0;
      csn_prev_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      csn_prev_r <= csn_s;
      if (state_r == smws_pkg::SMWS_STOP && state_nxt == smws_pkg::SMWS_NREQ) begin
        origin_r <= smws_pkg::ORG_STOP;
      end else if (state_r == smws_pkg::SMWS_SLEEP && state_nxt == smws_pkg::SMWS_RESET) begin
        origin_r <= smws_pkg::ORG_SLEEP;
      end else if (state_r == smws_pkg::SMWS_NREQ && state_nxt == smws_pkg::SMWS_RESET) begin
        origin_r <= smws_pkg::ORG_POWER;
      end
      if (state_r != smws_pkg::SMWS_RUN || run_cmd_in || sleep_cmd_in) begin
        stop_pending_r <= 1'b0;
      end else if (stop_cmd_in) begin
        stop_pending_r <= 1'b1;
      end
    end
  end

  // Wake source flags: hardware set wins over a software clear in the same cycle.
  logic [1:0] src_set;
  assign src_set[smws_pkg::WSRC_CAN] = in_stop & wake_s.can_wake; // R08
  assign src_set[smws_pkg::WSRC_INPUT] = in_stop & wake_s.input_wake; // R08 R09

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_src_r <= 2'h0;
    end else begin
      wake_src_r <= src_set | (wake_src_clear_in ? 2'h0 : wake_src_r);
    end
  end

  // Interrupt pulse starts the cycle after Normal Request is entered, so mode leads the pin.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_n_r <= 1'b1;
      spi_ready_r <= 1'b1;
      rst_n_r <= 1'b0;
    end else begin
      int_n_r <= ~(ip_busy & ~ip_start); // R07 R06 R19
      spi_ready_r <= ~(ip_busy | fs_busy | ip_start | fs_start); // R10
      rst_n_r <= (state_nxt != smws_pkg::SMWS_RESET) && (state_nxt != smws_pkg::SMWS_SLEEP) && !wd_expire; // R12 R16
    end
  end

  assign rst_n_out = rst_n_r;
  assign int_n_out = int_n_r;
  assign spi_ready_out = spi_ready_r;
  assign wake_src_out = wake_src_r;
  assign mode_out = state_r;

endmodule

// ### shared/smws_pkg.sv
// Shared constants and types of the operating-mode and wake sequencer.
package smws_pkg;

  localparam int CLK_MHZ = 125;
  // Normal Request timeout in milliseconds.
  localparam int NRQ_TIMEOUT_MS = 350;
  localparam int NRQ_TIMEOUT_CYC = NRQ_TIMEOUT_MS * CLK_MHZ * 1000;
  // Reset hold duration in milliseconds.
  localparam int RST_HOLD_MS = 15;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * CLK_MHZ * 1000;
  // Wake interrupt pulse width in microseconds.
  localparam int INT_PULSE_US = 10;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  // Over-current deglitch after Stop entry in microseconds.
  localparam int OC_DEGLITCH_US = 40;
  localparam int OC_DEGLITCH_CYC = OC_DEGLITCH_US * CLK_MHZ;
  // Delay from the end of the interrupt pulse to the first SPI access, microseconds.
  localparam int FIRST_SPI_US = 20;
  localparam int FIRST_SPI_CYC = FIRST_SPI_US * CLK_MHZ;
  // Stop watchdog period in milliseconds.
  localparam int STOP_WATCHDOG_FAULT_OUTPUT_MS = 100;
  localparam int STOP_WATCHDOG_FAULT_OUTPUT_CYC = STOP_WATCHDOG_FAULT_OUTPUT_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 32;

  // Origin of the current Normal Request visit.
  localparam logic [1:0] ORG_POWER = 2'h0;
  localparam logic [1:0] ORG_STOP = 2'h1;
  localparam logic [1:0] ORG_SLEEP = 2'h2;

  // Wake source flag positions in the recorded wake sources.
  localparam int WSRC_CAN = 0;
  localparam int WSRC_INPUT = 1;

  typedef enum logic [2:0] {
    SMWS_RESET = 3'b000,
    SMWS_NREQ = 3'b001,
    SMWS_RUN = 3'b011,
    SMWS_STOP = 3'b010,
    SMWS_SLEEP = 3'b110
  } smws_state_t;

  // Chip-side wake events seen in Stop.
  typedef struct packed {
    logic can_wake;
    logic input_wake;
    logic forced_wake;
    logic over_current;
  } smws_wake_t;

endpackage
